// *** design/cieg_pkg.sv ***
// Shared constants and carrier types for the CPU interrupt enable gate
// Assumes a single 40 MHz CPU clock and a synchronous active-high reset
package cieg_pkg;

    // Register geometry
    localparam int CIEG_WIDTH      = 16;                // Enable and flag width
    localparam int CIEG_LVL_W      = 4;                 // Level index width
    localparam int CIEG_RTOS_BIT   = 15;                // Real-time OS level
    localparam int CIEG_DLOG_BIT   = 14;                // Data-logging level
    localparam int CIEG_NUM_TOP    = 13;                // Numbered level 14
    localparam int CIEG_NUM_BOTTOM = 0;                 // Numbered level 1

    // Reset values and encodings
    localparam logic [15:0] CIEG_ENABLE_RESET = 16'h0000; // All levels off
    localparam logic [15:0] CIEG_FLAG_RESET   = 16'h0000; // Nothing pending
    localparam logic [15:0] CIEG_ONE_HOT_BASE = 16'h0001; // Bit 0 select
    localparam logic [15:0] CIEG_ALL_ZERO     = 16'h0000; // Empty mask
    localparam logic [3:0]  CIEG_LVL_ZERO     = 4'h0;     // Level index 0
    localparam logic        CIEG_BIT_ON       = 1'b1;     // Level enabled
    localparam logic        CIEG_BIT_OFF      = 1'b0;     // Level disabled

    // Instruction kinds issued by the CPU pipeline
    typedef enum logic [2:0] {
        CIEG_OP_NONE,                                   // No effect
        CIEG_OP_SET,                                    // OR into enables
        CIEG_OP_CLEAR,                                  // AND into enables
        CIEG_OP_SOFTWARE_LEVEL_REQUEST_INSTR,                                   // Software level request
        CIEG_OP_TRAP                                    // Trap request
    } cieg_op_t;

    // Instruction carrier
    typedef struct packed {
        logic            valid;                         // One-cycle strobe
        cieg_op_t        op;                            // Instruction kind
        logic [15:0]     operand;                       // Set or clear mask
        logic [3:0]      level;                         // Level for SOFTWARE_LEVEL_REQUEST_INSTR/TRAP
    } cieg_instr_t;

    // Pending flag write carrier
    typedef struct packed {
        logic            valid;                         // One-cycle strobe
        logic [15:0]     data;                          // Zeros clear flags
    } cieg_flag_wr_t;

    // Acknowledge carrier towards the sequencer
    typedef struct packed {
        logic            valid;                         // One-cycle pulse
        logic [3:0]      level;                         // Acknowledged bit
    } cieg_ack_t;

endpackage : cieg_pkg

// *** design/cieg_pending_flags.sv ***
// Pending flag register, one sticky bit per maskable level
// Assumes set pulses from request sources and clear masks from the CPU
`timescale 1ns/1ps

module cieg_pending_flags (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Set and clear masks
    input  wire logic [15:0] set_in,
    input  wire logic [15:0] clear_in,
    // Current flags
    output logic [15:0]      flags_out
);
    import cieg_pkg::*;

    logic [15:0] flag_reg;                              // Sticky pending bits

    // One flop per level; a new request beats a clear in the same cycle
    for (genvar i = 0; i < CIEG_WIDTH; i++) begin : g_flag
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                flag_reg[i] <= CIEG_FLAG_RESET[i];      // Nothing pending
            end else if (set_in[i]) begin
                flag_reg[i] <= CIEG_BIT_ON;
            end else if (clear_in[i]) begin
                flag_reg[i] <= CIEG_BIT_OFF;
            end
        end
    end

    assign flags_out = flag_reg;

endmodule : cieg_pending_flags

// *** design/cieg_level_pick.sv ***
// Picks the highest-priority eligible level from a 16-bit vector
// Assumes lower bit index means higher priority, bit 15 lowest
`timescale 1ns/1ps

module cieg_level_pick (
    // Candidate levels
    input  wire logic [15:0] eligible_in,
    // Result
    output logic             any_out,
    output logic [3:0]       index_out
);
    import cieg_pkg::*;

    // Scan downward so the lowest set bit is the last to win
    always_comb begin
        any_out   = |eligible_in;
        index_out = CIEG_LVL_ZERO;
        for (int i = CIEG_WIDTH - 1; i >= 0; i--) begin
            if (eligible_in[i]) begin
                index_out = 4'(i);
            end
        end
    end

endmodule : cieg_level_pick

// *** design/cieg_top.sv ***
// CPU interrupt enable register with acknowledge gating
// Assumes all inputs are synchronous to SYS_CLK_IN (40 MHz)
// Assumes the sequencer samples ACK_OUT one cycle after ACK_READY_IN
`timescale 1ns/1ps

module cieg_top (
    // Clock and reset
    input  wire logic                  SYS_CLK_IN,
    input  wire logic                  SRST_IN,
    // CPU instruction strobe
    input  wire cieg_pkg::cieg_instr_t   INSTR_IN,
    // Pending flag writes from the CPU
    input  wire cieg_pkg::cieg_flag_wr_t FLAG_WR_IN,
    // Request pulses from interrupt sources
    input  wire logic [15:0]           LEVEL_REQ_IN,
    // Sequencer side
    input  wire logic                  GLOBAL_IRQ_MASK_IN,
    input  wire logic                  ACK_READY_IN,
    input  wire logic                  NMI_IN,
    // Register views
    output logic [15:0]                LEVEL_ENABLE_OUT,
    output logic [15:0]                PENDING_FLAG_OUT,
    // Acknowledge and non-maskable path
    output cieg_pkg::cieg_ack_t        ACK_OUT,
    output logic                       NMI_REQ_OUT
);
    import cieg_pkg::*;

    // Enable register state
    logic [15:0] level_enable_reg;                      // One bit per level
    logic [15:0] level_enable_next;                     // Next enable value
    // Pending flags and eligibility
    logic [15:0] pending_flags;                         // Flag register view
    logic [15:0] eligible;                              // Ackable levels
    logic        any_eligible;                          // Some level ackable
    logic [3:0]  pick_index;                            // Winning level
    // Acknowledge path
    logic        ack_fire;                              // Ack issued now
    logic [15:0] ack_clr_mask;                          // Serviced level bit
    logic [15:0] software_level_request_instr_clr_mask;                         // SOFTWARE_LEVEL_REQUEST_INSTR level bit
    logic [15:0] auto_clr_mask;                         // All auto-clears
    logic [15:0] flag_clr_mask;                         // Flag clear sources
    cieg_ack_t   ack_reg;                               // Registered ack
    logic        nmi_req_reg;                           // Ungated NMI copy
    // Decoded instruction strobes
    logic        instr_set;                             // Set instruction
    logic        instr_clear;                           // Clear instruction
    logic        instr_software_level_request_instr;                            // Software request
    logic        instr_trap;                            // Trap request

    // Instruction decode
    // Only one kind can be valid per cycle; op NONE decodes to nothing
    always_comb begin
        instr_set   = INSTR_IN.valid && (INSTR_IN.op == CIEG_OP_SET);
        instr_clear = INSTR_IN.valid && (INSTR_IN.op == CIEG_OP_CLEAR);
        instr_software_level_request_instr  = INSTR_IN.valid && (INSTR_IN.op == CIEG_OP_SOFTWARE_LEVEL_REQUEST_INSTR);
        instr_trap  = INSTR_IN.valid && (INSTR_IN.op == CIEG_OP_TRAP);
    end

    // A level is eligible only when enabled, pending and unmasked.
    // All sixteen bits take part, numbered, RTOS and logging levels alike,
    // and only a one in the enable register lets a level through
    always_comb begin
        eligible = level_enable_reg & pending_flags;
        if (GLOBAL_IRQ_MASK_IN) begin
            eligible = CIEG_ALL_ZERO;
        end
    end

    // Priority pick among eligible levels; lowest bit index wins, so
    // level one beats level fourteen and the RTOS level comes last
    cieg_level_pick cieg_level_pick_inst (
        .eligible_in (eligible),
        .any_out     (any_eligible),
        .index_out   (pick_index)
    );

    // Acknowledge when the sequencer is ready
    assign ack_fire = ACK_READY_IN && any_eligible;

    // Masks of bits cleared by hardware service and software request
    // Trap requests are left out on purpose: the handler clears by hand
    always_comb begin
        ack_clr_mask  = CIEG_ALL_ZERO;
        software_level_request_instr_clr_mask = CIEG_ALL_ZERO;
        if (ack_fire) begin
            ack_clr_mask = CIEG_ONE_HOT_BASE << pick_index;
        end
        if (instr_software_level_request_instr) begin
            software_level_request_instr_clr_mask = CIEG_ONE_HOT_BASE << INSTR_IN.level;
        end
        auto_clr_mask = ack_clr_mask | software_level_request_instr_clr_mask;
    end

    // Next enable value: instruction first, auto-clear on top
    // Applying the auto-clear last means a set of the acked bit in the same
    // cycle leaves it clear, so one request is never serviced twice
    always_comb begin
        level_enable_next = level_enable_reg;
        case (1'b1)
            instr_set: begin
                level_enable_next = level_enable_reg | INSTR_IN.operand;
            end
            instr_clear: begin
                level_enable_next = level_enable_reg & INSTR_IN.operand;
            end
            default: begin
                level_enable_next = level_enable_reg;
            end
        endcase
        level_enable_next = level_enable_next & ~auto_clr_mask;
    end

    // Enable register, cleared by reset
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            level_enable_reg <= CIEG_ENABLE_RESET;
        end else begin
            level_enable_reg <= level_enable_next;
        end
    end

    // Flag clear sources: zero writes, service and software request
    always_comb begin
        flag_clr_mask = auto_clr_mask;
        if (FLAG_WR_IN.valid) begin
            flag_clr_mask = flag_clr_mask | ~FLAG_WR_IN.data;
        end
    end

    // Pending flag register; a request beats any clear in the same cycle,
    // so a source that fires while its level is serviced is not lost
    cieg_pending_flags cieg_pending_flags_inst (
        .clk_in    (SYS_CLK_IN),
        .rst_in    (SRST_IN),
        .set_in    (LEVEL_REQ_IN),
        .clear_in  (flag_clr_mask),
        .flags_out (pending_flags)
    );

    // Acknowledge register towards the sequencer
    // The level field follows the pick every cycle; it only counts with valid
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            ack_reg.valid <= CIEG_BIT_OFF;
            ack_reg.level <= CIEG_LVL_ZERO;
        end else begin
            ack_reg.valid <= ack_fire;
            ack_reg.level <= pick_index;
        end
    end

    // Non-maskable request passes with no enable term
    // Neither the enables nor the global mask reach this path
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            nmi_req_reg <= CIEG_BIT_OFF;
        end else begin
            nmi_req_reg <= NMI_IN;
        end
    end

    // Register views; bit layout follows level numbering
    // Bit 15 is the RTOS level, bit 14 data logging, bit n-1 level n
    assign LEVEL_ENABLE_OUT = level_enable_reg;
    assign PENDING_FLAG_OUT = pending_flags;
    assign ACK_OUT          = ack_reg;
    assign NMI_REQ_OUT      = nmi_req_reg;

    // Checks on the enable and acknowledge logic
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (SRST_IN);

    // Ack only for an enabled, pending level under a clear mask.
    // The acked bit is rebuilt as a one-hot mask, because an index taken
    // inside the past value would point at the level of the cycle before
    a_ack_needs_enable: assert property (
        !$past(SRST_IN) && ack_reg.valid |->
            (($past(level_enable_reg & pending_flags) &
              (CIEG_ONE_HOT_BASE << ack_reg.level)) != CIEG_ALL_ZERO) &&
            !$past(GLOBAL_IRQ_MASK_IN))
        else $error("ack for a disabled, idle or masked level");

    // Ready with an eligible level yields an ack next cycle
    a_eligible_gets_ack: assert property (
        ACK_READY_IN && |(level_enable_reg & pending_flags) &&
        !GLOBAL_IRQ_MASK_IN ##1 !SRST_IN |-> ack_reg.valid)
        else $error("eligible level was not acknowledged");

    // Enable bit of the acked level is already clear with the ack
    a_ack_clears_enable: assert property (
        !$past(SRST_IN) && ack_reg.valid |->
            !level_enable_reg[ack_reg.level] && !$past(ack_reg.valid) ||
            !level_enable_reg[ack_reg.level])
        else $error("enable bit not cleared with its ack");

    // Set instruction forces operand bits on unless auto-cleared
    a_set_or_bits: assert property (
        instr_set |=>
            (level_enable_reg & $past(INSTR_IN.operand)) ==
            ($past(INSTR_IN.operand) & ~$past(auto_clr_mask)))
        else $error("set instruction lost a bit");

    // Set instruction never clears a bit outside the auto-clear
    a_set_keeps_rest: assert property (
        instr_set |=>
            (($past(level_enable_reg) & ~$past(auto_clr_mask)) &
             ~level_enable_reg) == CIEG_ALL_ZERO)
        else $error("set instruction cleared a bit");

    // Clear instruction zeroes the zero bits and keeps the others unless auto-cleared
    a_clear_and_bits: assert property (
        instr_clear |=>
            level_enable_reg ==
            ($past(level_enable_reg) & $past(INSTR_IN.operand) &
             ~$past(auto_clr_mask)))
        else $error("clear instruction result wrong");

    // Software request clears its level enable
    a_software_level_request_instr_clears: assert property (
        instr_software_level_request_instr |=> !level_enable_reg[$past(INSTR_IN.level)])
        else $error("software request left enable set");

    // Trap leaves enables unless an ack clears one
    a_trap_keeps: assert property (
        instr_trap && !ack_fire |=> $stable(level_enable_reg))
        else $error("trap changed the enable register");

    // Reset leaves every enable bit clear
    a_reset_zero: assert property (disable iff (1'b0)
        SRST_IN |=> level_enable_reg == CIEG_ENABLE_RESET)
        else $error("enables not clear after reset");

    // NMI follows its input whatever the enables hold
    a_nmi_ungated: assert property (
        !$past(SRST_IN) |-> NMI_REQ_OUT == $past(NMI_IN))
        else $error("non-maskable request was gated");

    // A request pulse always leaves its flag set
    a_flag_set_wins: assert property (
        |LEVEL_REQ_IN |=> (pending_flags & $past(LEVEL_REQ_IN)) ==
                          $past(LEVEL_REQ_IN))
        else $error("request lost against a clear");

    // A set global mask lets no acknowledge out in the next cycle
    a_mask_blocks_ack: assert property (
        GLOBAL_IRQ_MASK_IN |=> !ack_reg.valid)
        else $error("ack issued under the global mask");

    // No acknowledge while the sequencer is not ready
    a_ready_gates_ack: assert property (
        !ACK_READY_IN |=> !ack_reg.valid)
        else $error("ack issued without ready");

    // The acked level is the lowest eligible bit index
    a_ack_lowest_level: assert property (
        ack_reg.valid |->
            ($past(level_enable_reg & pending_flags) &
             ((CIEG_ONE_HOT_BASE << ack_reg.level) - CIEG_ONE_HOT_BASE)) ==
            CIEG_ALL_ZERO)
        else $error("ack skipped a higher-priority level");

    // The acked level loses its flag unless a new request came with it
    a_ack_clears_flag: assert property (
        ack_reg.valid |->
            (pending_flags & ~$past(LEVEL_REQ_IN) &
             (CIEG_ONE_HOT_BASE << ack_reg.level)) == CIEG_ALL_ZERO)
        else $error("serviced level still pending");

    // A zero write clears its flags unless a request lands with it
    a_flag_zero_clear: assert property (
        FLAG_WR_IN.valid |=>
            (pending_flags & ~$past(FLAG_WR_IN.data) & ~$past(LEVEL_REQ_IN)) ==
            CIEG_ALL_ZERO)
        else $error("zero write left a flag set");

    // Software request also drops the pending flag of its level
    a_software_level_request_instr_clears_flag: assert property (
        instr_software_level_request_instr && !LEVEL_REQ_IN[INSTR_IN.level] |=>
            !pending_flags[$past(INSTR_IN.level)])
        else $error("software request left its flag set");

    // Main scenarios
    c_software_level_request_instr_seen: cover property (instr_software_level_request_instr);
    c_ack_rtos: cover property (ack_reg.valid && ack_reg.level == 4'(CIEG_RTOS_BIT));
    c_ack_dlog: cover property (ack_reg.valid && ack_reg.level == 4'(CIEG_DLOG_BIT));
    c_mask_block: cover property (ACK_READY_IN && GLOBAL_IRQ_MASK_IN &&
                                  |(level_enable_reg & pending_flags));
    c_trap_seen: cover property (instr_trap ##1 level_enable_reg != CIEG_ALL_ZERO);

endmodule : cieg_top

// *** test/cieg_seq_model.sv ***
// Sequencer model: offers ready unless stalled and counts acknowledges
// Assumes ACK_OUT of the gate is sampled on the rising edge of clk_in
`timescale 1ns/1ps

module cieg_seq_model (
    // Clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    // Stall control and acknowledge from the gate
    input  wire logic                stall_in,
    input  wire cieg_pkg::cieg_ack_t ack_in,
    // Sequencer state
    output logic                     ready_out,
    output logic [7:0]               ack_count_out,
    output logic [3:0]               last_level_out
);
    import cieg_pkg::*;

    // Ready trails stall by one cycle, as a slow sequencer would
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ready_out      <= 1'b0;
            ack_count_out  <= 8'h00;
            last_level_out <= 4'h0;
        end else begin
            ready_out <= !stall_in;
            // Each acknowledge pulse is one serviced level
            if (ack_in.valid === 1'b1) begin
                ack_count_out  <= ack_count_out + 8'h01;
                last_level_out <= ack_in.level;
            end
        end
    end
endmodule : cieg_seq_model

// *** test/cieg_top_tb_top.sv ***
// Self-checking bench for the CPU interrupt enable gate
// Assumes the sequencer model sits on the acknowledge side
`timescale 1ns/1ps

module cieg_top_tb_top;
    import cieg_pkg::*;

    logic          clk;        // 40 MHz clock
    logic          srst;       // Synchronous reset
    cieg_instr_t   instr;      // Instruction strobe
    cieg_flag_wr_t flag_wr;    // Flag write strobe
    logic [15:0]   req;        // Request pulses
    logic          mask;       // Global mask
    logic          stall;      // Sequencer stall
    logic          nmi;        // Non-maskable request
    logic          ready;      // Sequencer ready
    logic [15:0]   enables;    // Enable view
    logic [15:0]   flags;      // Flag view
    cieg_ack_t     ack;        // Acknowledge
    logic          nmi_req;    // Delayed NMI
    logic [7:0]    acks;       // Acks seen by model
    logic [3:0]    last_lvl;   // Last acked level
    int            n_fail;     // Mismatch count
    int            checks_done; // Comparison count

    cieg_top cieg_top_inst (.SYS_CLK_IN(clk), .SRST_IN(srst), .INSTR_IN(instr),
        .FLAG_WR_IN(flag_wr), .LEVEL_REQ_IN(req), .GLOBAL_IRQ_MASK_IN(mask),
        .ACK_READY_IN(ready), .NMI_IN(nmi), .LEVEL_ENABLE_OUT(enables),
        .PENDING_FLAG_OUT(flags), .ACK_OUT(ack), .NMI_REQ_OUT(nmi_req));

    cieg_seq_model cieg_seq_model_inst (.clk_in(clk), .rst_in(srst), .stall_in(stall),
        .ack_in(ack), .ready_out(ready), .ack_count_out(acks), .last_level_out(last_lvl));

    // Clock generator
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One instruction, taken at the second edge
    task automatic op(input cieg_op_t k, input logic [15:0] v, input logic [3:0] l);
        @(posedge clk);
        instr <= '{1'b1, k, v, l};
        @(posedge clk);
        instr <= '0;
        #1;
    endtask : op

    // One cycle of request pulses
    task automatic pulse_req(input logic [15:0] v);
        @(posedge clk);
        req <= v;
        @(posedge clk);
        req <= '0;
        #1;
    endtask : pulse_req

    // One pending flag write
    task automatic wr_flags(input logic [15:0] v);
        @(posedge clk);
        flag_wr <= '{1'b1, v};
        @(posedge clk);
        flag_wr <= '0;
        #1;
    endtask : wr_flags

    // Everything clear after reset
    task automatic t_reset;
        check(enables, 16'h0000);
        check(flags, 16'h0000);
        check({15'h0000, ack.valid}, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    // OR and AND updates, bit 15 left alone by every mask
    task automatic t_set_clear;
        op(CIEG_OP_SET, 16'h0003, 4'h0);
        check(enables, 16'h0003);
        op(CIEG_OP_SET, 16'h2001, 4'h0);
        check(enables, 16'h2003);
        op(CIEG_OP_CLEAR, 16'hfffe, 4'h0);
        check(enables, 16'h2002);
        op(CIEG_OP_NONE, 16'hffff, 4'h0);
        check(enables, 16'h2002);
        op(CIEG_OP_CLEAR, 16'h8000, 4'h0);
        check(enables, 16'h0000);
        $display("test set_clear done");
    endtask : t_set_clear

    // Gating of one level by enable and mask, then its acknowledge
    task automatic t_gate(input int b);
        logic [15:0] one;
        logic [7:0]  c0;
        one = 16'h0001 << b;
        c0  = acks;
        @(posedge clk);
        mask  <= 1'b0;
        stall <= 1'b0;
        pulse_req(one);
        check(flags & one, one);
        repeat (3) @(posedge clk);
        #1;
        check({8'h00, acks}, {8'h00, c0});
        @(posedge clk);
        mask <= 1'b1;
        op(CIEG_OP_SET, one, 4'h0);
        repeat (2) @(posedge clk);
        #1;
        check({8'h00, acks}, {8'h00, c0});
        @(posedge clk);
        mask <= 1'b0;
        @(posedge clk);
        #1;
        check({15'h0000, ack.valid}, 16'h0001);
        check({12'h000, ack.level}, b[15:0]);
        check(enables & one, 16'h0000);
        check(flags & one, 16'h0000);
        @(posedge clk);
        #1;
        check({15'h0000, ack.valid}, 16'h0000);
        check({8'h00, acks}, {8'h00, c0 + 8'h01});
        check({12'h000, last_lvl}, b[15:0]);
        @(posedge clk);
        mask <= 1'b1;
        $display("test gate bit %0d done", b);
    endtask : t_gate

    // Software request clears, trap does not; handler clears by hand
    task automatic t_software_level_request_instr_trap;
        op(CIEG_OP_SET, 16'h0030, 4'h0);
        pulse_req(16'h0030);
        op(CIEG_OP_SOFTWARE_LEVEL_REQUEST_INSTR, 16'h0000, 4'h4);
        check(enables, 16'h0020);
        check(flags, 16'h0020);
        op(CIEG_OP_TRAP, 16'h0000, 4'h5);
        check(enables, 16'h0020);
        op(CIEG_OP_CLEAR, 16'hffdf, 4'h0);
        check(enables, 16'h0000);
        wr_flags(16'hffdf);
        check(flags, 16'h0000);
        $display("test software_level_request_instr_trap done");
    endtask : t_software_level_request_instr_trap

    // Mid-run reset clears enables and flags again
    task automatic t_mid_reset;
        op(CIEG_OP_SET, 16'h4001, 4'h0);
        pulse_req(16'h0002);
        check(enables, 16'h4001);
        check(flags, 16'h0002);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1;
        check(enables, 16'h0000);
        check(flags, 16'h0000);
        $display("test mid_reset done");
    endtask : t_mid_reset

    // NMI passes with all enables off and mask set
    task automatic t_nmi;
        @(posedge clk);
        nmi <= 1'b1;
        @(posedge clk);
        nmi <= 1'b0;
        #1;
        check({15'h0000, nmi_req}, 16'h0001);
        @(posedge clk);
        #1;
        check({15'h0000, nmi_req}, 16'h0000);
        $display("test nmi done");
    endtask : t_nmi

    // Counts and verdict
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        n_fail      = 0;
        checks_done = 0;
        srst        = 1'b1;
        instr       = '0;
        flag_wr     = '0;
        req         = '0;
        mask        = 1'b1;
        stall       = 1'b1;
        nmi         = 1'b0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_set_clear();
        t_gate(0);
        t_gate(13);
        t_gate(14);
        t_software_level_request_instr_trap();
        t_mid_reset();
        t_nmi();
        finish_test();
    end

    // Watchdog, far beyond the fewer than 100 cycles the tests need
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
endmodule : cieg_top_tb_top
